// file: pkg/ubd_defines.svh
// Constants for the buffer descriptor manager: register offsets, fields.
// Assumes a 32-bit APB slave and a dedicated DMA word port.
`ifndef UBD_DEFINES_SVH
`define UBD_DEFINES_SVH
`define UBD_REG_CTRL     12'h000
`define UBD_REG_BASE     12'h004
`define UBD_REG_STATUS   12'h008
`define UBD_REG_LAST     12'h00c
`define UBD_CTRL_RST     32'h0000_0000
`define UBD_BASE_RST     32'h0000_0000
`define UBD_OWN_BIT      7
`define UBD_PID_LSB      2
`define UBD_CNT_LSB      16
`define UBD_DESC_BYTES   8
`define UBD_NUM_DESC     64
`endif

// file: pkg/ubd_pkg.sv
// Types for the buffer descriptor manager.
// Assumes ubd_defines.svh is in the include path.
package ubd_pkg;
  typedef enum logic [1:0] {
    UBD_MODE_NONE  = 2'b00,
    UBD_MODE_EP0RX = 2'b01,
    UBD_MODE_ALL   = 2'b10,
    UBD_MODE_NOEP0 = 2'b11
  } ubd_mode_e;

  // request from the engine: which endpoint, direction, result
  typedef struct packed {
    logic [3:0]  ep;
    logic        tx;
    logic [3:0]  pid;
    logic [9:0]  count;
  } ubd_tok_s;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } ubd_dma_s;

  typedef enum logic [2:0] {
    UBD_IDLE  = 3'b000,
    UBD_RDREQ = 3'b001,
    UBD_CHECK = 3'b010,
    UBD_WRREQ = 3'b011,
    UBD_DONE  = 3'b100
  } ubd_state_e;
endpackage : ubd_pkg

// file: verilog/ubd_manager.sv
// Buffer descriptor manager: maps endpoint/direction to a descriptor,
// checks ownership over the DMA port and writes back pid and count.
// Assumes a single-cycle-grant DMA memory and an APB master on pclk.
`include "ubd_defines.svh"
`timescale 1ns/1ns
module ubd_manager (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          tok_valid,
  input  wire ubd_pkg::ubd_tok_s tok,
  output logic               tok_ready,
  output logic               tok_done,
  output logic               tok_owned,
  output logic      [5:0]    tok_desc,
  output ubd_pkg::ubd_dma_s  dma_o,
  input  wire logic          dma_gnt,
  input  wire logic          dma_rvalid,
  input  wire logic [31:0]   dma_rdata
);
  import ubd_pkg::*;

  // ==========================================================
  // registers
  logic [31:0] ctrl_ff;
  logic [31:0] base_ff;
  logic [15:0] pp_rx_ff;
  logic [15:0] pp_tx_ff;
  logic [5:0]  last_ff;
  logic        last_own_ff;
  ubd_state_e  state_ff;
  ubd_state_e  nxt_state;
  ubd_tok_s    tok_ff;
  logic [5:0]  desc_ff;
  logic        done_ff;
  logic        owned_ff;
  ubd_dma_s    dma_ff;
  ubd_dma_s    nxt_dma;

  wire ubd_mode_e mode = ubd_mode_e'(ctrl_ff[1:0]);

  // ==========================================================
  // APB decode; zero wait states, unmapped reads zero and error
  wire apb_acc   = psel & penable;
  wire apb_wr    = apb_acc & pwrite;
  wire hit_ctrl  = (paddr == `UBD_REG_CTRL);
  wire hit_base  = (paddr == `UBD_REG_BASE);
  wire hit_stat  = (paddr == `UBD_REG_STATUS);
  wire hit_last  = (paddr == `UBD_REG_LAST);
  wire hit_any   = hit_ctrl | hit_base | hit_stat | hit_last;
  wire [31:0] rd_stat = {16'h0000, 13'h0, state_ff};
  wire [31:0] rd_last = {24'h000000, last_own_ff, 1'b0, last_ff};
  assign pready  = 1'b1;
  assign pslverr = apb_acc & ~hit_any;
  assign prdata  = hit_ctrl ? ctrl_ff :
                   hit_base ? base_ff :
                   hit_stat ? rd_stat :
                   hit_last ? rd_last : 32'h0000_0000;

  // ==========================================================
  // descriptor index selection
  wire [3:0] ep     = tok_ff.ep;
  wire       tx     = tok_ff.tx;
  wire       pp_odd = tx ? pp_tx_ff[ep] : pp_rx_ff[ep];
  wire [5:0] ep2    = {1'b0, ep, 1'b0};
  wire [5:0] ep4    = {ep, 2'b00};
  wire [5:0] idx_m0 = ep2 + {5'h00, tx};
  wire [5:0] idx_m1 = (ep == 4'h0) ?
                      (tx ? 6'h02 : {5'h00, pp_odd}) :
                      (ep2 + 6'h01 + {5'h00, tx});
  wire [5:0] idx_m2 = ep4 + {4'h0, tx, pp_odd};
  wire [5:0] idx_m3 = (ep == 4'h0) ? {5'h00, tx} :
                      (ep4 - 6'h02 + {4'h0, tx, pp_odd});
  wire [5:0] idx_sel = (mode == UBD_MODE_NONE)  ? idx_m0 :
                       (mode == UBD_MODE_EP0RX) ? idx_m1 :
                       (mode == UBD_MODE_ALL)   ? idx_m2 : idx_m3;
  wire ep_pp = (mode == UBD_MODE_ALL) |
               ((mode == UBD_MODE_NOEP0) & (ep != 4'h0)) |
               ((mode == UBD_MODE_EP0RX) & (ep == 4'h0) & ~tx);

  // descriptor address on dedicated DMA path
  wire [31:0] desc_addr = base_ff + {23'h0, desc_ff, 3'b000};
  // read address from the live index: desc_ff lags one cycle in RDREQ
  wire [31:0] rd_addr   = base_ff + {23'h0, idx_sel, 3'b000};
  // engine layout: own, pid, count; core bits dropped
  wire [31:0] wb_word = {6'h00, tok_ff.count, 8'h00,
                         1'b0, 1'b0, tok_ff.pid, 2'b00};
  // engine may update when flag set
  wire        own_set = dma_rdata[`UBD_OWN_BIT];

  // ==========================================================
  // sequencer next state
  always_comb begin
    nxt_state = state_ff;
    nxt_dma   = dma_ff;
    case (state_ff)
      UBD_IDLE: begin
        if (tok_valid) begin
          nxt_state = UBD_RDREQ;
        end
      end
      UBD_RDREQ: begin
        nxt_dma = '{req: 1'b1, we: 1'b0, addr: rd_addr,
                    wdata: 32'h0000_0000};
        if (dma_ff.req & dma_gnt) begin
          nxt_dma.req = 1'b0;
          nxt_state   = UBD_CHECK;
        end
      end
      UBD_CHECK: begin
        if (dma_rvalid) begin
          nxt_state = UBD_DONE;
          if (own_set) begin
            nxt_state = UBD_WRREQ;
          end
        end
      end
      UBD_WRREQ: begin
        nxt_dma = '{req: 1'b1, we: 1'b1, addr: desc_addr,
                    wdata: wb_word};
        if (dma_ff.req & dma_gnt) begin
          nxt_dma.req = 1'b0;
          nxt_state   = UBD_DONE;
        end
      end
      UBD_DONE: begin
        nxt_state = UBD_IDLE;
      end
      default: begin
        nxt_state = UBD_IDLE;
      end
    endcase
  end

  // ==========================================================
  // control registers written over APB
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `UBD_CTRL_RST;
      base_ff <= `UBD_BASE_RST;
    end else if (apb_wr) begin
      if (hit_ctrl) begin
        ctrl_ff <= {30'h0, pwdata[1:0]};
      end
      if (hit_base) begin
        base_ff <= {pwdata[31:3], 3'b000};
      end
    end
  end

  // sequencer state and DMA request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= UBD_IDLE;
      dma_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      dma_ff   <= nxt_dma;
    end
  end

  // token capture and descriptor index
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tok_ff  <= '0;
      desc_ff <= 6'h00;
    end else begin
      if (state_ff == UBD_IDLE && tok_valid) begin
        tok_ff <= tok;
      end
      if (state_ff == UBD_RDREQ) begin
        desc_ff <= idx_sel;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pp_rx_ff <= 16'h0000;
      pp_tx_ff <= 16'h0000;
    end else if (state_ff == UBD_WRREQ && nxt_state == UBD_DONE
                 && ep_pp) begin
      if (tx) begin
        pp_tx_ff[ep] <= ~pp_tx_ff[ep];
      end else begin
        pp_rx_ff[ep] <= ~pp_rx_ff[ep];
      end
    end
  end

  // result; a clear flag leaves memory untouched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_ff     <= 1'b0;
      owned_ff    <= 1'b0;
      last_ff     <= 6'h00;
      last_own_ff <= 1'b0;
    end else begin
      done_ff <= (nxt_state == UBD_DONE);
      if (nxt_state == UBD_DONE) begin
        owned_ff    <= (state_ff == UBD_WRREQ);
        last_ff     <= desc_ff;
        last_own_ff <= (state_ff == UBD_WRREQ) ? 1'b1 : 1'b0;
      end
    end
  end

  // core owns write discipline; nothing enforced here
  assign tok_ready = (state_ff == UBD_IDLE);
  assign tok_done  = done_ff;
  assign tok_owned = owned_ff;
  assign tok_desc  = last_ff;
  assign dma_o     = dma_ff;
endmodule : ubd_manager

// file: test/ubd_mem_model.sv
// DMA-side memory shared with firmware, holding the descriptor table.
// Assumes word requests from the manager's registered DMA port.
`timescale 1ns/1ns
module ubd_mem_model (
  input  wire logic              pclk,
  input  wire logic              slow,
  input  wire ubd_pkg::ubd_dma_s dma_o,
  output logic                   dma_gnt,
  output logic                   dma_rvalid,
  output logic [31:0]            dma_rdata
);
  import ubd_pkg::*;
  // ==========================
  // one contiguous table
  logic [31:0] mem [0:255];
  logic [31:0] q;
  logic [1:0]  cnt = 2'h0;
  // slow grants one cycle in four
  assign dma_gnt = dma_o.req && (!slow || cnt == 2'h0);
  // idle bus shows inverse, never a stale word
  assign dma_rdata = dma_rvalid ? q : ~q;
  always @(posedge pclk) begin
    cnt <= cnt + 2'h1;
    dma_rvalid <= dma_gnt && !dma_o.we;
    if (dma_gnt && dma_o.we)
      mem[dma_o.addr[9:2]] <= dma_o.wdata;
    if (dma_gnt && !dma_o.we)
      q <= mem[dma_o.addr[9:2]];
  end
endmodule : ubd_mem_model

// file: test/ubd_manager_sva.sv
// Assertions on the manager's APB, token and DMA ports.
// Bound into every ubd_manager instance.
`timescale 1ns/1ns
module ubd_manager_sva (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic [11:0]       paddr,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              tok_valid,
  input wire logic              tok_ready,
  input wire logic              tok_done,
  input wire logic              tok_owned,
  input wire ubd_pkg::ubd_dma_s dma_o,
  input wire logic              dma_gnt,
  input wire logic              dma_rvalid,
  input wire logic [31:0]       dma_rdata
);
  import ubd_pkg::*;
  // ==========================
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire take = tok_valid && tok_ready;
  wire rd = dma_rvalid;
  property p_rdy; acc |-> pready; endproperty
  property p_err; acc && paddr > 12'h00c |-> pslverr; endproperty
  property p_ok;
    acc && paddr < 12'h010 && paddr[1:0] == 2'b00 |-> !pslverr;
  endproperty
  property p_busy; take |=> !tok_ready; endproperty
  property p_rd; take |-> ##[1:3] dma_o.req && !dma_o.we; endproperty
  property p_hold;
    dma_o.req && !dma_gnt |=> dma_o.req && $stable(dma_o.addr);
  endproperty
  property p_keep; rd && !dma_rdata[7] |=> !dma_o.we [*4]; endproperty
  property p_wb;
    rd && dma_rdata[7] |-> ##[1:3] dma_o.we && !dma_o.wdata[7];
  endproperty
  property p_done; take |-> ##[3:60] tok_done; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  a_err: assert property (p_err) else $error("no slave error");
  a_ok: assert property (p_ok) else $error("false slave error");
  a_busy: assert property (p_busy) else $error("ready while busy");
  a_rd: assert property (p_rd) else $error("no table read");
  a_hold: assert property (p_hold) else $error("dma dropped");
  a_keep: assert property (p_keep) else $error("core slot hit");
  a_wb: assert property (p_wb) else $error("no writeback");
  a_done: assert property (p_done) else $error("token hung");
  c_own: cover property (tok_done && tok_owned);
  c_free: cover property (tok_done && !tok_owned);
  c_err: cover property (acc && pslverr);
endmodule : ubd_manager_sva
bind ubd_manager ubd_manager_sva u_sva (.*);

// file: test/ubd_manager_bench.sv
// Self-checking bench: APB setup, then tokens in all four modes.
// Assumes the memory model answers every DMA request.
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
  mismatches++; $display("ERROR %0t: got %h want %h", $time, a, b); end end
module ubd_manager_bench;
  import ubd_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, slow;
  logic tok_valid, tok_ready, tok_done, tok_owned, dma_gnt, dma_rvalid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, dma_rdata, rd, seed, tog;
  logic [5:0]  tok_desc;
  ubd_tok_s    tok;
  ubd_dma_s    dma_o;
  int          mismatches, checks_done;
  // ==========================
  ubd_manager uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .tok_valid, .tok, .tok_ready,
    .tok_done, .tok_owned, .tok_desc, .dma_o, .dma_gnt, .dma_rvalid,
    .dma_rdata);
  ubd_mem_model u_mem (.pclk, .slow, .dma_o, .dma_gnt, .dma_rvalid,
    .dma_rdata);
  function automatic logic [5:0] idx(input logic [1:0] m,
    input logic [3:0] e, input logic t, input logic o);
    logic [5:0] n;
    n = {2'h0, e};
    case (m)
      2'h0: return 6'(2 * n + t);
      2'h1: return e == 4'h0 ? (t ? 6'h2 : {5'h0, o}) : 6'(2 * n + 1 + t);
      2'h2: return 6'(4 * n + 2 * t + o);
      default: return e == 4'h0 ? {5'h0, t} : 6'(4 * n - 2 + 2 * t + o);
    endcase
  endfunction : idx
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic apb(input logic w, input logic [11:0] a);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so the next call never reassigns psel in this step
    @(posedge pclk);
  endtask : apb
  task automatic run(input logic [1:0] m, input logic [3:0] e,
                     input logic t, input logic own);
    logic [5:0] x;
    logic [7:0] w;
    x = idx(m, e, t, tog[{e, t}]);
    w = 8'h40 + {1'b0, x, 1'b0};
    // firmware fills an idle slot only
    u_mem.mem[w] = {seed[31:8], own, seed[6:0]};
    tok <= '{ep: e, tx: t, pid: seed[3:0], count: seed[17:8]};
    tok_valid <= 1'b1;
    @(posedge pclk);
    tok_valid <= 1'b0;
    do @(posedge pclk); while (tok_done !== 1'b1);
    `CHK(tok_desc, x)
    `CHK(tok_owned, own)
    `CHK(u_mem.mem[w], own ? {6'h0, seed[17:8], 10'h0, seed[3:0], 2'h0} : {seed[31:8], 1'b0, seed[6:0]})
    if (own && (m == 2'h2 || (m == 2'h1 && e == 4'h0 && !t) || (m == 2'h3 && e != 4'h0)))
      tog[{e, t}] = !tog[{e, t}];
    apb(1'b0, 12'h00c);
    `CHK({rd[7], rd[5:0]}, {own, x})
  endtask : run
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    repeat (12000) @(posedge pclk);
    mismatches++;
    $display("ERROR %0t: timeout", $time);
    test_done();
  end
  initial begin
    {presetn, psel, penable, pwrite, tok_valid, slow} = 6'h0;
    {paddr, pwdata, tok} = '0;
    seed = 32'h7dad260f;
    for (int m = 0; m < 4; m++) begin
      // each mode starts from reset, so ping-pong restarts even
      presetn <= 1'b0;
      tog = '0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, 12'h000);
      `CHK(rd, 32'h0)
      pwdata <= 32'h103;
      apb(1'b1, 12'h004);
      pwdata <= 32'(m);
      apb(1'b1, 12'h000);
      apb(1'b0, 12'h004);
      `CHK(rd, 32'h100)
      apb(1'b0, 12'h010);
      `CHK({err, rd}, {1'b1, 32'h0})
      slow <= m[0];
      for (int i = 0; i < 14; i++) begin
        seed = xs(seed);
        run(2'(m), i < 4 ? {4{~i[1]}} : seed[23:20], i >= 4 && seed[24],
            i < 4 || seed[25]);
      end
    end
    test_done();
  end
endmodule : ubd_manager_bench
